// ---- design/sea_consts.svh ----
// Constants for the serial nonvolatile array block: opcodes, status layout,
// reset values, timing. Included by the core only; definitions only.
`ifndef SEA_CONSTS_SVH
`define SEA_CONSTS_SVH

// ==========================================================
// Opcodes
`define SEA_OP_ENABLE_WRITE   8'h06
`define SEA_OP_DISABLE_WRITE  8'h04
`define SEA_OP_READ_STATUS    8'h05
`define SEA_OP_WRITE_STATUS   8'h01
`define SEA_OP_ARRAY_READ_LO  3'h3
`define SEA_OP_ARRAY_WRITE_LO 3'h2
`define SEA_OP_ADDR8_POS      3

// ==========================================================
// Status word fields and reset values
`define SEA_STATUS_RESET      8'h30
`define SEA_TIMEOUT_RESET     2'h3
`define SEA_PROTECT_RESET     2'h0
`define SEA_TIMEOUT_LSB       4
`define SEA_PROTECT_LSB       2

// ==========================================================
// Timing
`define SEA_CLOCK_PERIOD_NS   5
`define SEA_WRITE_TIME_NS     10000000
`define SEA_WRITE_CYCLES      (`SEA_WRITE_TIME_NS / `SEA_CLOCK_PERIOD_NS)
`define SEA_TIMEOUT_00_MS     11'h578
`define SEA_TIMEOUT_01_MS     11'h258
`define SEA_TIMEOUT_10_MS     11'h0c8

`endif

// ---- design/sea_core.sv ----
// Serial command logic for a 512 x 8 nonvolatile array and its status word.
// Assumes a free-running i_clock and a host-driven serial clock that may stop.
`timescale 1ns/1ps
`default_nettype none
`include "sea_consts.svh"

module sea_core
	import sea_pkg::*;
#(
	parameter int P_WRITE_CYCLES = `SEA_WRITE_CYCLES
) (
	// System clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	// Serial link
	input  wire logic               i_sck,
	input  wire logic               i_cs_n,
	input  wire logic               i_si,
	output logic                    o_so,
	output logic                    o_so_oe_n,
	// Write protect pin
	input  wire logic               i_wp_n,
	// State seen by the rest of the chip
	output sea_pkg::sea_status_t    o_status_word,
	output logic [10:0]             o_watchdog_period_ms,
	output logic                    o_watchdog_on
);
	import sea_pkg::*;

	// Busy must outlast the eight-cycle hold check below
	if (P_WRITE_CYCLES < 8) begin : g_check
		$error("P_WRITE_CYCLES must be at least eight");
	end

	// ==========================================================
	// System-domain storage
	logic [7:0]  mem_reg [0:511];
	logic [1:0]  timeout_reg;
	logic [1:0]  protect_reg;
	logic        wel_reg;
	logic        busy_reg;
	logic [31:0] busy_cnt_reg;

	// ==========================================================
	// Link-domain registers
	sea_lstate_t lstate_reg;
	sea_lstate_t lstate_next;
	logic [2:0]  bit_cnt_reg;
	logic [6:0]  shift_reg;
	sea_kind_t   kind_reg;
	sea_kind_t   kind_next;
	logic        byte_done_reg;
	logic        frame_tog_reg;
	logic [8:0]  addr_reg;
	logic [7:0]  page_buf_reg [0:15];
	logic [15:0] loaded_reg;
	logic [7:0]  st_data_reg;
	logic [7:0]  out_byte_reg;
	logic        so_reg;
	logic        drive_reg;
	logic        busy_meta_reg;
	logic        busy_l_reg;
	logic        wel_meta_reg;
	logic        wel_l_reg;

	// ==========================================================
	// Link decode
	wire [7:0] rx_byte    = {shift_reg, i_si};
	wire       byte_end   = (bit_cnt_reg == 3'h7);
	wire       first_edge = (lstate_reg == SEA_L_OPCODE) && (bit_cnt_reg == 3'h0);
	wire       op_high0   = (rx_byte[7:4] == 4'h0);
	wire       is_enable  = (rx_byte == `SEA_OP_ENABLE_WRITE);
	wire       is_disable = (rx_byte == `SEA_OP_DISABLE_WRITE);
	wire       is_rstatus = (rx_byte == `SEA_OP_READ_STATUS);
	wire       is_wstatus = (rx_byte == `SEA_OP_WRITE_STATUS);
	wire       is_aread   = op_high0 && (rx_byte[2:0] == `SEA_OP_ARRAY_READ_LO);
	wire       is_awrite  = op_high0 && (rx_byte[2:0] == `SEA_OP_ARRAY_WRITE_LO);
	wire       out_state  = (lstate_reg == SEA_L_RDATA) || (lstate_reg == SEA_L_STATUS_OUT);
	// Fields are taken as static: they only move at the start of a programming cycle
	wire [7:0] status_l   = {2'h0, timeout_reg, protect_reg, wel_l_reg, busy_l_reg};
	wire [8:0] next_addr  = addr_reg + 9'h001;
	wire [8:0] rd_index   = (lstate_reg == SEA_L_ADDR) ? {addr_reg[8], rx_byte} : next_addr;
	wire [7:0] out_next   = ((lstate_reg == SEA_L_OPCODE) || (lstate_reg == SEA_L_STATUS_OUT))
	                        ? status_l : mem_reg[rd_index];
	wire       done_next  = byte_end && ((lstate_reg == SEA_L_OPCODE) ||
	                        (lstate_reg == SEA_L_WDATA) || (lstate_reg == SEA_L_WSTATUS));

	always_comb begin
		lstate_next = lstate_reg;
		kind_next   = SEA_KIND_NONE;
		case (lstate_reg)
			SEA_L_OPCODE: begin
				if (byte_end) begin
					lstate_next = SEA_L_IGNORE;
					if (is_rstatus) begin
						lstate_next = SEA_L_STATUS_OUT;
					end else if (busy_l_reg) begin
						lstate_next = SEA_L_IGNORE;
					end else if (is_enable) begin
						kind_next = SEA_KIND_ENABLE;
					end else if (is_disable) begin
						kind_next = SEA_KIND_DISABLE;
					end else if (is_wstatus) begin
						kind_next   = SEA_KIND_WSTATUS;
						lstate_next = SEA_L_WSTATUS;
					end else if (is_aread) begin
						kind_next   = SEA_KIND_READ;
						lstate_next = SEA_L_ADDR;
					end else if (is_awrite) begin
						kind_next   = SEA_KIND_WARRAY;
						lstate_next = SEA_L_ADDR;
					end
				end
			end
			SEA_L_ADDR: begin
				if (byte_end) begin
					lstate_next = (kind_reg == SEA_KIND_WARRAY) ? SEA_L_WDATA : SEA_L_RDATA;
				end
			end
			SEA_L_WSTATUS: begin
				if (byte_end) begin
					lstate_next = SEA_L_IGNORE;
				end
			end
			default: begin
				lstate_next = lstate_reg;
			end
		endcase
	end

	// ==========================================================
	// Frame state: select high returns it to the opcode phase
	always_ff @(posedge i_sck or posedge i_rst or posedge i_cs_n) begin
		if (i_rst || i_cs_n) begin
			lstate_reg  <= SEA_L_OPCODE;
			bit_cnt_reg <= 3'h0;
			shift_reg   <= 7'h00;
		end else begin
			lstate_reg  <= lstate_next;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg   <= rx_byte[6:0];
		end
	end

	// Frame results survive the select rise so the core can take them over
	always_ff @(posedge i_sck or posedge i_rst) begin
		if (i_rst) begin
			kind_reg      <= SEA_KIND_NONE;
			byte_done_reg <= 1'b0;
			frame_tog_reg <= 1'b0;
			addr_reg      <= 9'h000;
			loaded_reg    <= 16'h0000;
			st_data_reg   <= 8'h00;
			out_byte_reg  <= 8'h00;
		end else begin
			byte_done_reg <= done_next;
			if (first_edge) begin
				frame_tog_reg <= ~frame_tog_reg;
				loaded_reg    <= 16'h0000;
			end
			if (byte_end) begin
				out_byte_reg <= out_next;
			end
			if (byte_end && (lstate_reg == SEA_L_OPCODE)) begin
				kind_reg    <= kind_next;
				addr_reg[8] <= rx_byte[`SEA_OP_ADDR8_POS];
			end
			if (byte_end && (lstate_reg == SEA_L_ADDR)) begin
				addr_reg[7:0] <= rx_byte;
			end
			if (byte_end && (lstate_reg == SEA_L_RDATA)) begin
				addr_reg <= next_addr;
			end
			if (byte_end && (lstate_reg == SEA_L_WDATA)) begin
				loaded_reg[addr_reg[3:0]] <= 1'b1;
				addr_reg[3:0]             <= addr_reg[3:0] + 4'h1;
			end
			if (byte_end && (lstate_reg == SEA_L_WSTATUS)) begin
				st_data_reg <= rx_byte;
			end
		end
	end

	// Page buffer holds data only, no reset needed
	always_ff @(posedge i_sck) begin
		if (byte_end && (lstate_reg == SEA_L_WDATA)) begin
			page_buf_reg[addr_reg[3:0]] <= rx_byte;
		end
	end

	// Output shifts on the falling edge, MSB first
	always_ff @(negedge i_sck or posedge i_rst or posedge i_cs_n) begin
		if (i_rst || i_cs_n) begin
			so_reg    <= 1'b0;
			drive_reg <= 1'b0;
		end else begin
			drive_reg <= out_state;
			so_reg    <= out_byte_reg[~bit_cnt_reg];
		end
	end

	assign o_so      = so_reg;
	assign o_so_oe_n = ~drive_reg;

	// Busy and latch into the link domain
	always_ff @(posedge i_sck or posedge i_rst) begin
		if (i_rst) begin
			busy_meta_reg <= 1'b0;
			busy_l_reg    <= 1'b0;
			wel_meta_reg  <= 1'b0;
			wel_l_reg     <= 1'b0;
		end else begin
			busy_meta_reg <= busy_reg;
			busy_l_reg    <= busy_meta_reg;
			wel_meta_reg  <= wel_reg;
			wel_l_reg     <= wel_meta_reg;
		end
	end

	// ==========================================================
	// System domain: select, frame toggle and pin synchronisers
	logic cs_meta_reg;
	logic cs_q_reg;
	logic cs_prev_reg;
	logic tog_meta_reg;
	logic tog_q_reg;
	logic tog_seen_reg;
	logic wp_meta_reg;
	logic wp_q_reg;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cs_meta_reg  <= 1'b1;
			cs_q_reg     <= 1'b1;
			cs_prev_reg  <= 1'b1;
			tog_meta_reg <= 1'b0;
			tog_q_reg    <= 1'b0;
			tog_seen_reg <= 1'b0;
			wp_meta_reg  <= 1'b0;
			wp_q_reg     <= 1'b0;
		end else begin
			cs_meta_reg  <= i_cs_n;
			cs_q_reg     <= cs_meta_reg;
			cs_prev_reg  <= cs_q_reg;
			tog_meta_reg <= frame_tog_reg;
			tog_q_reg    <= tog_meta_reg;
			wp_meta_reg  <= i_wp_n;
			wp_q_reg     <= wp_meta_reg;
			if (cs_q_reg && !cs_prev_reg) begin
				tog_seen_reg <= tog_q_reg;
			end
		end
	end

	// A frame with no clock edge leaves the toggle alone and commits nothing
	wire cs_rise      = cs_q_reg && !cs_prev_reg;
	wire new_frame    = cs_rise && (tog_q_reg != tog_seen_reg) && !busy_reg;
	wire cmd_enable   = new_frame && byte_done_reg && (kind_reg == SEA_KIND_ENABLE);
	wire cmd_disable  = new_frame && byte_done_reg && (kind_reg == SEA_KIND_DISABLE);
	wire wr_ok        = new_frame && byte_done_reg && wel_reg && wp_q_reg;
	wire arr_prot     = (protect_reg == 2'h3) ||
	                    ((protect_reg == 2'h2) && addr_reg[8]) ||
	                    ((protect_reg == 2'h1) && (addr_reg[8:7] == 2'h3));
	wire start_status = wr_ok && (kind_reg == SEA_KIND_WSTATUS);
	wire start_array  = wr_ok && (kind_reg == SEA_KIND_WARRAY) && (|loaded_reg) &&
	                    !arr_prot;
	wire busy_done    = busy_reg && (busy_cnt_reg == 32'h1);

	// ==========================================================
	// Latch, busy and fields
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wel_reg      <= 1'b0;
			busy_reg     <= 1'b0;
			busy_cnt_reg <= 32'h0;
			timeout_reg  <= `SEA_TIMEOUT_RESET;
			protect_reg  <= `SEA_PROTECT_RESET;
		end else begin
			if (!wp_q_reg || busy_done || cmd_disable) begin
				wel_reg <= 1'b0;
			end else if (cmd_enable) begin
				wel_reg <= 1'b1;
			end
			if (start_status || start_array) begin
				busy_reg     <= 1'b1;
				busy_cnt_reg <= 32'(P_WRITE_CYCLES);
			end else if (busy_reg) begin
				busy_reg     <= !busy_done;
				busy_cnt_reg <= busy_cnt_reg - 32'h1;
			end
			if (start_status) begin
				timeout_reg <= st_data_reg[`SEA_TIMEOUT_LSB +: 2];
				protect_reg <= st_data_reg[`SEA_PROTECT_LSB +: 2];
			end
		end
	end

	// Only loaded bytes of the page are programmed
	always_ff @(posedge i_clock) begin
		for (int i = 0; i < 16; i++) begin
			if (start_array && loaded_reg[i]) begin
				mem_reg[{addr_reg[8:4], 4'(i)}] <= page_buf_reg[i];
			end
		end
	end

	// ==========================================================
	// Outputs to the chip
	wire [10:0] period_next = (timeout_reg == 2'h0) ? `SEA_TIMEOUT_00_MS :
	                          (timeout_reg == 2'h1) ? `SEA_TIMEOUT_01_MS :
	                          (timeout_reg == 2'h2) ? `SEA_TIMEOUT_10_MS : 11'h000;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_status_word        <= sea_status_t'(`SEA_STATUS_RESET);
			o_watchdog_period_ms <= 11'h000;
			o_watchdog_on        <= 1'b0;
		end else begin
			o_status_word        <= {2'h0, timeout_reg, protect_reg, wel_reg, busy_reg};
			o_watchdog_period_ms <= period_next;
			o_watchdog_on        <= (timeout_reg != 2'h3);
		end
	end

	// ==========================================================
	// Checks
	sequence s_prog_start;
		$rose(busy_reg);
	endsequence

	property p_status_layout;
		@(posedge i_clock) disable iff (i_rst)
		o_status_word.zero_bits == 2'h0 && $past(busy_reg) == o_status_word.busy_programming_flag;
	endproperty
	a_status_layout: assert property (p_status_layout) else $error("status layout wrong");

	property p_busy_holds;
		@(posedge i_clock) disable iff (i_rst)
		s_prog_start |-> busy_reg [*8];
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");

	property p_latch_after_prog;
		@(posedge i_clock) disable iff (i_rst)
		$fell(busy_reg) |-> !wel_reg;
	endproperty
	a_latch_after_prog: assert property (p_latch_after_prog) else $error("latch kept");

	property p_write_needs_enable;
		@(posedge i_clock) disable iff (i_rst)
		s_prog_start |-> $past(wel_reg) && $past(wp_q_reg) && $past(byte_done_reg);
	endproperty
	a_write_needs_enable: assert property (p_write_needs_enable) else $error("unguarded write");

	property p_protected_refused;
		@(posedge i_clock) disable iff (i_rst)
		(kind_reg == SEA_KIND_WARRAY) && arr_prot |-> !start_array;
	endproperty
	a_protected_refused: assert property (p_protected_refused) else $error("protected write");

	property p_fields_by_wstatus;
		@(posedge i_clock) disable iff (i_rst)
		$changed(protect_reg) || $changed(timeout_reg) |-> $past(start_status);
	endproperty
	a_fields_by_wstatus: assert property (p_fields_by_wstatus) else $error("field changed");

	property p_busy_refuses;
		@(posedge i_clock) disable iff (i_rst)
		busy_reg |-> !start_status && !start_array && !cmd_enable;
	endproperty
	a_busy_refuses: assert property (p_busy_refuses) else $error("command while busy");

	property p_disable_clears;
		@(posedge i_clock) disable iff (i_rst)
		cmd_disable |=> !wel_reg ##1 !o_status_word.write_enable_flag;
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("latch not cleared");

	property p_read_wrap;
		@(posedge i_sck) disable iff (i_rst || i_cs_n)
		(lstate_reg == SEA_L_RDATA) && byte_end && (addr_reg == 9'h1ff) |=> addr_reg == 9'h000;
	endproperty
	a_read_wrap: assert property (p_read_wrap) else $error("read wrap wrong");

	property p_page_wrap;
		@(posedge i_sck) disable iff (i_rst || i_cs_n)
		(lstate_reg == SEA_L_WDATA) && byte_end |=> addr_reg[8:4] == $past(addr_reg[8:4]);
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page left");

endmodule

`default_nettype wire

// ---- design/sea_pkg.sv ----
// Types shared by the serial nonvolatile array block.
// Assumes sea_consts.svh on the include path.
package sea_pkg;

	// ==========================================================
	// Status word carrier
	typedef struct packed {
		logic [1:0] zero_bits;
		logic [1:0] timeout_field;
		logic [1:0] protect_field;
		logic       write_enable_flag;
		logic       busy_programming_flag;
	} sea_status_t;

	// ==========================================================
	// Frame kinds handed from the link to the core
	typedef enum logic [2:0] {
		SEA_KIND_NONE,
		SEA_KIND_ENABLE,
		SEA_KIND_DISABLE,
		SEA_KIND_READ,
		SEA_KIND_WSTATUS,
		SEA_KIND_WARRAY
	} sea_kind_t;

	// ==========================================================
	// Link states
	typedef enum logic [2:0] {
		SEA_L_OPCODE,
		SEA_L_ADDR,
		SEA_L_RDATA,
		SEA_L_WDATA,
		SEA_L_STATUS_OUT,
		SEA_L_WSTATUS,
		SEA_L_IGNORE
	} sea_lstate_t;

endpackage

// ---- dv/sea_host_model.sv ----
// Host-side serial master for the nonvolatile array block.
// Assumes the bench calls frame() one at a time; i_clock only aligns edges.
`timescale 1ns/1ps
`default_nettype none

module sea_host_model (
	// Bench clock for edge alignment
	input  wire logic i_clock,
	// Serial link
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si,
	input  wire logic i_so,
	input  wire logic i_so_oe_n
);
	// ==========================================================
	// Frame engine
	logic drove;

	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b1;
		drove = 1'b0;
	end

	// Sends whole bytes, then extra stray bits to break a frame on purpose
	task automatic frame(input logic [7:0] tx[$], input int extra, output logic [7:0] rx[$]);
		logic [7:0] b;
		int         n;
		rx = {};
		b = 8'h00;
		drove = 1'b0;
		n = tx.size() * 8 + extra;
		@(negedge i_clock);
		// Offset keeps link edges clear of system clock edges
		#1.7;
		o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_si = (i < tx.size() * 8) ? tx[i / 8][7 - i % 8] : 1'b1;
			#40 o_sck = 1'b1;
			// Undriven line shows the inverse, so a stale bit cannot pass
			b = {b[6:0], (i_so_oe_n === 1'b0) ? i_so : ~i_so};
			if (i_so_oe_n === 1'b0) begin
				drove = 1'b1;
			end
			if (i % 8 == 7) begin
				rx.push_back(b);
			end
			#40 o_sck = 1'b0;
		end
		// Select rises only after a falling edge; clock stands still after
		#40 o_cs_n = 1'b1;
		o_si = ~o_si;
		#200;
	endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for sea_core: status, array and protection traffic.
// Assumes sea_pkg, sea_host_model and a short programming time.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import sea_pkg::*;
	// ==========================================================
	// Signals
	localparam int P_WC = 600;
	logic        i_clock;
	logic        i_rst;
	logic        i_wp_n;
	wire         sck;
	wire         cs_n;
	wire         si;
	wire         so;
	wire         so_oe_n;
	sea_status_t st;
	logic [10:0] wd_ms;
	logic        wd_on;
	int          num_errors;
	int          checks_done;
	logic [7:0]  mem_exp[512];
	logic        mem_ok[512];
	logic [1:0]  tf;
	logic [1:0]  pf;
	logic [7:0]  rx[$];
	logic [7:0]  s;
	logic [8:0]  a;

	sea_core #(.P_WRITE_CYCLES(P_WC)) i_dut (
		.i_clock(i_clock), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
		.o_so(so), .o_so_oe_n(so_oe_n), .i_wp_n(i_wp_n), .o_status_word(st),
		.o_watchdog_period_ms(wd_ms), .o_watchdog_on(wd_on)
	);
	sea_host_model i_host (
		.i_clock(i_clock), .o_sck(sck), .o_cs_n(cs_n), .o_si(si),
		.i_so(so), .i_so_oe_n(so_oe_n)
	);

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	// ==========================================================
	// Expectations
	function automatic logic prot(input logic [8:0] ad, input logic [1:0] f);
		return (f == 2'h3) || (f == 2'h2 && ad[8]) || (f == 2'h1 && ad[8:7] == 2'h3);
	endfunction

	function automatic logic [10:0] wd_exp(input logic [1:0] t);
		case (t)
			2'h0: return 11'h578;
			2'h1: return 11'h258;
			2'h2: return 11'h0c8;
			default: return 11'h000;
		endcase
	endfunction

	// ==========================================================
	// Tasks
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_status(output logic [7:0] v);
		i_host.frame('{8'h05, 8'h00}, 0, rx);
		v = rx[1];
	endtask

	task automatic enable_write_cmd;
		i_host.frame('{8'h06}, 0, rx);
	endtask

	// Bounded wait for the programming cycle to end
	task automatic wait_idle;
		int n;
		n = 0;
		while (st.busy_programming_flag !== 1'b0 && n < 2000) begin
			@(negedge i_clock);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			tally_and_finish();
		end
	endtask

	task automatic wstatus(input logic [7:0] v);
		logic [7:0] r;
		enable_write_cmd();
		i_host.frame('{8'h01, v}, 0, rx);
		rd_status(r);
		chk("busy in status write", i_wp_n, r[0]);
		wait_idle();
		if (i_wp_n) begin
			tf = v[5:4];
			pf = v[3:2];
		end
		chk("status port", {2'h0, tf, pf, 2'h0}, st);
		rd_status(r);
		chk("status read", {2'h0, tf, pf, 2'h0}, r);
	endtask

	task automatic awrite(input logic [8:0] ad, input int n, input int extra, input logic en);
		logic [7:0] tx[$];
		logic [7:0] d[$];
		logic       go;
		logic [3:0] lo;
		// Without enable the latch is cleared first, so its state is known
		if (en) begin
			enable_write_cmd();
		end else begin
			i_host.frame('{8'h04}, 0, rx);
		end
		go = en && i_wp_n && extra == 0 && !prot(ad, pf);
		tx = '{{4'h0, ad[8], 3'h2}, ad[7:0]};
		for (int i = 0; i < n; i++) begin
			d.push_back(8'($urandom));
			tx.push_back(d[i]);
		end
		i_host.frame(tx, extra, rx);
		chk("busy after write", go, st.busy_programming_flag);
		if (go) begin
			i_host.frame('{8'h03, 8'h00, 8'h00}, 0, rx);
			chk("read while busy", 0, i_host.drove);
		end
		wait_idle();
		// A refused or abandoned write leaves the latch as it was
		chk("latch after write", en && i_wp_n && !go, st.write_enable_flag);
		for (int i = 0; i < n && go; i++) begin
			lo = ad[3:0] + 4'(i);
			mem_exp[{ad[8:4], lo}] = d[i];
			mem_ok[{ad[8:4], lo}] = 1'b1;
		end
	endtask

	task automatic aread(input logic [8:0] ad, input int n);
		logic [7:0] tx[$];
		logic [8:0] p;
		tx = '{{4'h0, ad[8], 3'h3}, ad[7:0]};
		repeat (n) tx.push_back(8'($urandom));
		i_host.frame(tx, 0, rx);
		chk("read drives", 1, i_host.drove);
		chk("output released", 1, so_oe_n);
		for (int i = 0; i < n; i++) begin
			p = ad + 9'(i);
			if (mem_ok[p]) begin
				chk("array byte", mem_exp[p], rx[i + 2]);
			end
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		num_errors = 0;
		checks_done = 0;
		i_rst = 1'b1;
		i_wp_n = 1'b1;
		tf = 2'h3;
		pf = 2'h0;
		foreach (mem_ok[i]) mem_ok[i] = 1'b0;
		void'($urandom(32'h44e296cf));
		repeat (4) @(negedge i_clock);
		i_rst = 1'b0;
		chk("reset status", 8'h30, st);
		chk("reset output off", 1, so_oe_n);
		chk("reset watchdog", 0, wd_on);
		repeat (4) @(negedge i_clock);
		rd_status(s);
		chk("status read", 8'h30, s);
		enable_write_cmd();
		chk("latch set", 1, st.write_enable_flag);
		i_host.frame('{8'h04}, 0, rx);
		chk("latch clear", 0, st.write_enable_flag);
		i_wp_n = 1'b0;
		enable_write_cmd();
		chk("latch pin low", 0, st.write_enable_flag);
		wstatus(8'h00);
		i_wp_n = 1'b1;
		for (int t = 0; t < 4; t++) begin
			wstatus({2'h3, 2'(t), 2'h0, 2'h3});
			chk("period", wd_exp(2'(t)), wd_ms);
			chk("watchdog on", t != 3, wd_on);
		end
		repeat (5) begin
			a = 9'($urandom);
			awrite(a, 1 + $urandom % 16, 0, 1'b1);
			aread({a[8:4], 4'h0}, 16);
		end
		awrite(9'h0a5, 18, 0, 1'b1);
		aread(9'h0a0, 16);
		awrite(9'h1ff, 1, 0, 1'b1);
		awrite(9'h000, 1, 0, 1'b1);
		aread(9'h1fe, 3);
		awrite(9'h0a3, 2, 3, 1'b1);
		awrite(9'h0a4, 1, 0, 1'b0);
		// Write aimed into the checked page, so a wrong commit shows in the read
		i_host.frame('{8'h06, 8'h02, 8'ha5, 8'h5a}, 0, rx);
		chk("no close after enable", 0, st.busy_programming_flag);
		chk("enable with extra bits", 0, st.write_enable_flag);
		aread(9'h0a0, 16);
		for (int f = 0; f < 5; f++) begin
			wstatus({4'h3, 2'(f % 4), 2'h0});
			foreach (mem_ok[j]) begin
				if (j == 0 || j == 9'h100 || j == 9'h180) begin
					awrite(9'(j), 1, 0, 1'b1);
					aread(9'(j), 1);
				end
			end
		end
		tally_and_finish();
	end
endmodule

`default_nettype wire
